// >>> rtl/fps_pkg.sv
// Constants and types shared by the flash boot pin-function select block
package fps_pkg;
   localparam logic [1:0] BOOT_NOR       = 2'h0;
   localparam logic [1:0] BOOT_SFLASH    = 2'h1;
   localparam logic [2:0] F_GPIO         = 3'h0;
   localparam logic [2:0] F_SFLASH_FUNC  = 3'h3;
   localparam logic [2:0] F_NAND_FUNC    = 3'h5;
   localparam logic [1:0] D_GPIO         = 2'h0;
   localparam logic [1:0] D_NAND_FUNC    = 2'h1;
   localparam int         NUM_F          = 4;
   localparam int         NUM_D          = 12;
   localparam logic [4:0] AREA0_WIDTH    = 5'h10;
   localparam int         ADDR_LOW_LINES = 20;
   localparam int         ADDR_HI_LINES  = 5;
   localparam int         F_CLOCK        = 0;
   localparam int         F_SELECT       = 1;
   localparam int         F_DATA_OUT     = 2;
   localparam int         F_DATA_IN      = 3;
   localparam int         SYN_BOOT_A     = 0;
   localparam int         SYN_BOOT_B     = 1;
   localparam int         SYN_EMU        = 2;
   localparam int         SYN_RB         = 3;
   localparam int         SYN_W          = 4;
   localparam int         DBG_STAGES     = 2;
   typedef enum logic {FPS_LOAD, FPS_RUN} fps_phase_t;
endpackage : fps_pkg

// >>> rtl/fps_debug_reset.sv
// Debug interface reset: asserts asynchronously, releases on the clock
`timescale 1ns/1ps
module fps_debug_reset #(
   parameter int STAGES = fps_pkg::DBG_STAGES
) (
   input  wire logic clock,
   input  wire logic debug_reset_n,
   output logic      debug_rst
);
   typedef struct packed {
      logic [STAGES-1:0] stage;
   } fps_dbg_t;

   fps_dbg_t q;
   fps_dbg_t d;

   always_comb begin
      d = q;
      d.stage = {q.stage[STAGES-2:0], 1'b1};
   end

   // [RULE14] async debug reset
   always_ff @(posedge clock or negedge debug_reset_n) begin
      if (!debug_reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Release is synchronous so debug logic never sees a runt deassertion
   assign debug_rst = ~q.stage[STAGES-1];

   a_dbg_reset_async : assert property ( // [RULE14]
      @(posedge clock) !debug_reset_n |-> debug_rst)
      else $error("debug reset not asserted while input low");
endmodule : fps_debug_reset

// >>> rtl/fps_pin_select.sv
// Boot strap capture and flash pin-function select
// Summary of operation
// [RULE1] Area 0 always uses a fixed 16-bit data bus width.
// [RULE2] Both boot pins low at reset selects boot mode 0, NOR boot.
// [RULE3] NOR boot enables A1-A20, D0-D15, read strobe and area-0 select.
// [RULE4] Board must hold NOR address inputs above A20 low until enabled.
// [RULE5] Byte-0 write strobe stays undriven until bus unit is programmed.
// [RULE6] Serial flash pins are GPIO until their 3-bit field reads 011.
// [RULE7] Serial-flash boot sets serial flash pin functions automatically.
// [RULE8] Data fields 01 select NAND; 3-bit fields 101 select CE and R/B.
// [RULE9] Shared data pins switch between bus and NAND automatically.
// [RULE10] Boot mode 0 defaults shared pins to bus/NAND, others to GPIO.
// [RULE11] No NAND command issues while ready/busy is low.
// [RULE12] Emulator select sampled during reset; low means emulator mode.
// [RULE13] Emulator select must stay stable one cycle after reset release.
// [RULE14] Low debug reset input resets debug logic asynchronously.
// [RULE15] Emulator drives debug reset timing, otherwise it is held low.
// [RULE16] Mode field writes act next cycle and hold until rewritten.
`timescale 1ns/1ps
module fps_pin_select (
   input  wire logic                         clock,
   input  wire logic                         sys_rst,
   input  wire logic                         boot_select_pin_a,
   input  wire logic                         boot_select_pin_b,
   input  wire logic                         emulator_mode_select_n,
   input  wire logic                         debug_reset_n,
   input  wire logic                         nand_ready_busy,
   input  wire logic [fps_pkg::NUM_F-1:0]    f_mode_we,
   input  wire logic [2:0]                   f_mode_wdata,
   input  wire logic [fps_pkg::NUM_D-1:0]    d_mode_we,
   input  wire logic [1:0]                   d_mode_wdata,
   input  wire logic                         bus_prog_we,
   input  wire logic [fps_pkg::ADDR_HI_LINES-1:0] hi_addr_wdata,
   input  wire logic                         nand_owns_bus,
   input  wire logic                         nand_cmd_req,
   input  wire logic                         bus_cs0_n,
   input  wire logic                         bus_rd_n,
   input  wire logic                         bus_we0_n,
   output logic [1:0]                        boot_mode,
   output logic                              boot_done,
   output logic                              emulator_mode,
   output logic [4:0]                        area0_bus_width,
   output logic [24:0]                       addr_line_en,
   output logic                              area0_select_n,
   output logic                              area0_select_oe,
   output logic                              read_strobe_n,
   output logic                              read_strobe_oe,
   output logic                              byte0_write_strobe_n,
   output logic                              byte0_write_strobe_oe,
   output logic [fps_pkg::NUM_F-1:0][2:0]    f_mode_q,
   output logic [fps_pkg::NUM_D-1:0][1:0]    d_mode_q,
   output logic [fps_pkg::NUM_F-1:0]         sflash_func,
   output logic                              nand_ce_func,
   output logic                              nand_rb_func,
   output logic [fps_pkg::NUM_D-1:0]         d_bus_func,
   output logic [fps_pkg::NUM_D-1:0]         d_nand_func,
   output logic                              d_low_bus_func,
   output logic                              nand_cmd_go,
   output logic                              debug_rst
);
   typedef struct packed {
      logic [fps_pkg::SYN_W-1:0]             meta;
      logic [fps_pkg::SYN_W-1:0]             sync;
      logic [1:0]                            boot_mode;
      logic                                  emu_n;
      fps_pkg::fps_phase_t                   phase;
      logic                                  bus_prog;
      logic [fps_pkg::ADDR_HI_LINES-1:0]     hi_en;
      logic [fps_pkg::NUM_F-1:0][2:0]        f_mode;
      logic [fps_pkg::NUM_D-1:0][1:0]        d_mode;
   } fps_state_t;

   fps_state_t q;
   fps_state_t d;

   function automatic logic f_is(input logic [2:0] m, input logic [2:0] c);
      f_is = (m == c);
   endfunction : f_is

   logic nor_cfg;
   logic bus_live;

   always_comb begin
      d = q;
      d.meta = {nand_ready_busy, emulator_mode_select_n,
                boot_select_pin_b, boot_select_pin_a};
      d.sync = q.meta;
      if (sys_rst) begin
         // [RULE2] strap capture
         d.boot_mode = {q.sync[fps_pkg::SYN_BOOT_B],
                        q.sync[fps_pkg::SYN_BOOT_A]};
         // [RULE12] emulator select capture
         d.emu_n    = q.sync[fps_pkg::SYN_EMU];
         d.phase    = fps_pkg::FPS_LOAD;
         d.bus_prog = 1'b0;
         d.hi_en    = '0;
         // [RULE6] GPIO by default
         d.f_mode   = {fps_pkg::NUM_F{fps_pkg::F_GPIO}};
         d.d_mode   = {fps_pkg::NUM_D{fps_pkg::D_GPIO}};
      end else begin
         unique case (q.phase)
            fps_pkg::FPS_LOAD: begin
               // [RULE7] loader sets serial pins
               if (q.boot_mode == fps_pkg::BOOT_SFLASH) begin
                  d.f_mode = {fps_pkg::NUM_F{fps_pkg::F_SFLASH_FUNC}};
               end
               // [RULE10] NOR boot shared-pin default
               if (q.boot_mode == fps_pkg::BOOT_NOR) begin
                  d.d_mode = {fps_pkg::NUM_D{fps_pkg::D_NAND_FUNC}};
               end
               d.phase = fps_pkg::FPS_RUN;
            end
            fps_pkg::FPS_RUN: begin
            end
         endcase
         // [RULE16] software field writes win
         for (int i = 0; i < fps_pkg::NUM_F; i++) begin
            if (f_mode_we[i]) begin
               d.f_mode[i] = f_mode_wdata;
            end
         end
         for (int i = 0; i < fps_pkg::NUM_D; i++) begin
            if (d_mode_we[i]) begin
               d.d_mode[i] = d_mode_wdata;
            end
         end
         if (bus_prog_we) begin
            d.bus_prog = 1'b1;
            d.hi_en    = hi_addr_wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      q <= d;
   end

   assign boot_mode     = q.boot_mode;
   assign boot_done     = (q.phase == fps_pkg::FPS_RUN);
   assign emulator_mode = ~q.emu_n;
   // [RULE1] fixed area-0 width
   assign area0_bus_width = fps_pkg::AREA0_WIDTH;

   // [RULE3] minimal NOR bus setup
   assign nor_cfg  = boot_done && (q.boot_mode == fps_pkg::BOOT_NOR);
   assign bus_live = nor_cfg | q.bus_prog;
   // [RULE4] upper lines stay off until software enables them
   assign addr_line_en = {q.hi_en & {fps_pkg::ADDR_HI_LINES{q.bus_prog}},
                          {fps_pkg::ADDR_LOW_LINES{bus_live}}};
   assign area0_select_n  = bus_cs0_n;
   assign area0_select_oe = bus_live;
   assign read_strobe_n   = bus_rd_n;
   assign read_strobe_oe  = bus_live;
   // [RULE5] write strobe floats until programmed
   assign byte0_write_strobe_n  = bus_we0_n;
   assign byte0_write_strobe_oe = q.bus_prog;

   assign f_mode_q = q.f_mode;
   assign d_mode_q = q.d_mode;

   genvar g;
   generate
      for (g = 0; g < fps_pkg::NUM_F; g++) begin : g_sflash
         // [RULE6] serial function on 011
         assign sflash_func[g] = f_is(q.f_mode[g], fps_pkg::F_SFLASH_FUNC);
      end
      for (g = 0; g < fps_pkg::NUM_D; g++) begin : g_dpin
         // [RULE9] automatic bus and NAND handover
         assign d_nand_func[g] = (q.d_mode[g] == fps_pkg::D_NAND_FUNC)
                                 && nand_owns_bus;
         assign d_bus_func[g]  = (q.d_mode[g] == fps_pkg::D_NAND_FUNC)
                                 && !nand_owns_bus;
      end
   endgenerate

   // [RULE8] CE and ready/busy on 101
   assign nand_ce_func = f_is(q.f_mode[fps_pkg::F_SELECT],
                              fps_pkg::F_NAND_FUNC);
   assign nand_rb_func = f_is(q.f_mode[fps_pkg::F_CLOCK],
                              fps_pkg::F_NAND_FUNC);
   // [RULE10] low data pins are bus pins only in NOR boot
   assign d_low_bus_func = nor_cfg;
   // [RULE11] hold commands while busy
   assign nand_cmd_go = nand_cmd_req && nand_ce_func && nand_rb_func
                        && q.sync[fps_pkg::SYN_RB];

   // Release is held back two clocks after the input rises
   fps_debug_reset #(
      .STAGES (fps_pkg::DBG_STAGES)
   ) fps_debug_reset_i (
      .clock         (clock),
      .debug_reset_n (debug_reset_n),
      .debug_rst     (debug_rst)
   );

   sequence s_release;
      $fell(sys_rst) ##0 (f_mode_we == '0) && (d_mode_we == '0);
   endsequence

   a_area0_width : assert property ( // [RULE1]
      @(posedge clock) disable iff (sys_rst)
      area0_bus_width == 5'h10)
      else $error("area 0 width not 16");
   a_nor_boot_bus : assert property ( // [RULE3]
      @(posedge clock) disable iff (sys_rst)
      s_release ##0 (q.boot_mode == 2'h0) |=>
      (addr_line_en[19:0] == 20'hFFFFF) && area0_select_oe
      && read_strobe_oe && (addr_line_en[24:20] == 5'h00))
      else $error("NOR boot bus setup missing");
   a_we0_float : assert property ( // [RULE5]
      @(posedge clock) disable iff (sys_rst)
      !$past(bus_prog_we) && !$past(q.bus_prog) |->
      !byte0_write_strobe_oe)
      else $error("write strobe driven before programming");
   a_sflash_boot : assert property ( // [RULE7]
      @(posedge clock) disable iff (sys_rst)
      s_release ##0 (q.boot_mode == 2'h1) |=>
      (sflash_func == 4'hF) ##1 boot_done)
      else $error("serial boot pins not set");
   a_other_default : assert property ( // [RULE10]
      @(posedge clock) disable iff (sys_rst)
      s_release ##0 (q.boot_mode != 2'h0) |=>
      (d_mode_q == '0) && !d_low_bus_func)
      else $error("shared pins not GPIO");
   a_handover : assert property ( // [RULE9]
      @(posedge clock) disable iff (sys_rst)
      (d_mode_q[0] == 2'h1) |->
      (d_nand_func[0] == nand_owns_bus) && (d_bus_func[0] != nand_owns_bus))
      else $error("bus and NAND handover wrong");
   a_busy_block : assert property ( // [RULE11]
      @(posedge clock) disable iff (sys_rst)
      !q.sync[fps_pkg::SYN_RB] || !nand_rb_func |-> !nand_cmd_go)
      else $error("NAND command while busy");
   a_emu_hold : assert property ( // [RULE12]
      @(posedge clock) disable iff (sys_rst)
      !$past(sys_rst) |-> $stable(emulator_mode))
      else $error("emulator mode changed after reset");
   a_field_write : assert property ( // [RULE16]
      @(posedge clock) disable iff (sys_rst)
      f_mode_we[3] && !$past(sys_rst) |=>
      (f_mode_q[3] == $past(f_mode_wdata)) ##1
      ($past(f_mode_we[3]) || $stable(f_mode_q[3])))
      else $error("mode field write not held");
   a_nand_select : assert property ( // [RULE8]
      @(posedge clock) disable iff (sys_rst)
      f_mode_we[1] && (f_mode_wdata == 3'h5) |=> nand_ce_func)
      else $error("NAND chip enable not selected");
endmodule : fps_pin_select

// >>> test/fps_board_model.sv
// Board side model: boot straps, NAND ready/busy, emulator reset line
`timescale 1ns/1ps
module fps_board_model (
   input  wire logic [1:0] strap_mode,
   input  wire logic       strap_emu_n,
   input  wire logic       flash_ready,
   input  wire logic       emu_attached,
   input  wire logic       emu_trst_n,
   input  wire logic [4:0] hi_addr_en,
   input  wire logic [4:0] hi_addr_drv,
   output logic            boot_select_pin_a,
   output logic            boot_select_pin_b,
   output logic            emulator_mode_select_n,
   output logic            nand_ready_busy,
   output logic            debug_reset_n,
   output logic [4:0]      nor_hi_addr
);
   // Straps are static board levels, held past release
   assign boot_select_pin_a      = strap_mode[0];
   assign boot_select_pin_b      = strap_mode[1];
   assign emulator_mode_select_n = strap_emu_n;
   // Ready/busy pulled up, flash pulls low while busy
   assign nand_ready_busy        = flash_ready;
   // Emulator times the reset, otherwise pulled low
   assign debug_reset_n          = emu_attached ? emu_trst_n : 1'b0;
   // Upper address inputs pulled low until enabled
   assign nor_hi_addr            = hi_addr_en & hi_addr_drv;
endmodule : fps_board_model

// >>> test/fps_pin_select_test.sv
// Directed testbench of the flash boot pin-function select block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; \
   if ((got) !== (ex)) begin fails++; \
   $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module fps_pin_select_test;
   logic clock, sys_rst, boot_select_pin_a, boot_select_pin_b;
   logic emulator_mode_select_n, debug_reset_n, nand_ready_busy;
   logic nand_owns_bus, nand_cmd_req, bus_cs0_n, bus_rd_n, bus_we0_n;
   logic bus_prog_we, boot_done, emulator_mode, area0_select_n;
   logic area0_select_oe, read_strobe_n, read_strobe_oe, nand_cmd_go;
   logic byte0_write_strobe_n, byte0_write_strobe_oe, debug_rst;
   logic nand_ce_func, nand_rb_func, d_low_bus_func;
   logic strap_emu_n, flash_ready, emu_attached, emu_trst_n;
   logic [1:0]       boot_mode, d_mode_wdata, strap_mode;
   logic [2:0]       f_mode_wdata;
   logic [3:0]       f_mode_we, sflash_func;
   logic [4:0]       area0_bus_width, hi_addr_wdata, hi_drv, nor_hi_addr;
   logic [11:0]      d_mode_we, d_bus_func, d_nand_func;
   logic [24:0]      addr_line_en;
   logic [3:0][2:0]  f_mode_q;
   logic [11:0][1:0] d_mode_q;
   int               fails, samples_checked;
   fps_pin_select fps_pin_select_i (.clock, .sys_rst, .boot_select_pin_a,
      .boot_select_pin_b, .emulator_mode_select_n, .debug_reset_n,
      .nand_ready_busy, .f_mode_we, .f_mode_wdata, .d_mode_we,
      .d_mode_wdata, .bus_prog_we, .hi_addr_wdata, .nand_owns_bus,
      .nand_cmd_req, .bus_cs0_n, .bus_rd_n, .bus_we0_n, .boot_mode,
      .boot_done, .emulator_mode, .area0_bus_width, .addr_line_en,
      .area0_select_n, .area0_select_oe, .read_strobe_n, .read_strobe_oe,
      .byte0_write_strobe_n, .byte0_write_strobe_oe, .f_mode_q, .d_mode_q,
      .sflash_func, .nand_ce_func, .nand_rb_func, .d_bus_func,
      .d_nand_func, .d_low_bus_func, .nand_cmd_go, .debug_rst);
   fps_board_model fps_board_model_i (.strap_mode, .strap_emu_n,
      .flash_ready, .emu_attached, .emu_trst_n,
      .hi_addr_en(addr_line_en[24:20]), .hi_addr_drv(hi_drv),
      .boot_select_pin_a, .boot_select_pin_b, .emulator_mode_select_n,
      .nand_ready_busy, .debug_reset_n, .nor_hi_addr);
   always #12.5 clock = ~clock;
   // Inputs move 2 ns after the edge, never on it
   task step;
      @(posedge clock) #2;
   endtask : step
   task wr(input logic [3:0] fw, input logic [11:0] dw, input logic [2:0] v);
      f_mode_we = fw; d_mode_we = dw; f_mode_wdata = v; d_mode_wdata = v[1:0];
      step();
      f_mode_we = 4'h0; d_mode_we = 12'h000;
      // An edge passes so back-to-back writes never reassign in one step
      step();
   endtask : wr
   task give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (3000) @(posedge clock);
      fails++;
      give_verdict();
   end
   initial begin
      clock = 0; sys_rst = 1; fails = 0; samples_checked = 0;
      f_mode_we = 4'h0; d_mode_we = 12'h000; f_mode_wdata = 3'h0;
      d_mode_wdata = 2'h0; bus_prog_we = 0; hi_addr_wdata = 5'h00;
      nand_owns_bus = 0; nand_cmd_req = 0; bus_cs0_n = 1; bus_rd_n = 1;
      bus_we0_n = 1; strap_mode = 2'h0; strap_emu_n = 1; flash_ready = 1;
      emu_attached = 1; emu_trst_n = 1; hi_drv = 5'h1F;
      for (int i = 0; i < 4; i++) begin
         sys_rst = 1; strap_mode = 2'(i); strap_emu_n = strap_mode[0];
         repeat (8) step();
         sys_rst = 0;
         repeat (2) step();
         `CHK("boot_mode", strap_mode, boot_mode)
         `CHK("emulator_mode", !strap_mode[0], emulator_mode)
         `CHK("area0_width", 5'h10, area0_bus_width)
         `CHK("boot_done", 1'b1, boot_done)
         `CHK("we0_oe", 1'b0, byte0_write_strobe_oe)
         `CHK("sflash", (i == 1) ? 4'hF : 4'h0, sflash_func)
         `CHK("low_bus", i == 0, d_low_bus_func)
         if (i == 0) begin
            `CHK("addr_en", 25'h00FFFFF, addr_line_en)
            `CHK("cs_rd", 2'h3, {area0_select_oe, read_strobe_oe})
            `CHK("nor_hi", 5'h00, nor_hi_addr)
            `CHK("d_bus", 12'hFFF, d_bus_func)
            nand_owns_bus = 1;
            step();
            `CHK("d_nand", 12'hFFF, d_nand_func)
            `CHK("d_bus", 12'h000, d_bus_func)
            nand_owns_bus = 0;
         end
      end
      wr(4'h3, 12'h000, 3'h5);
      `CHK("ce_rb", 2'h3, {nand_ce_func, nand_rb_func})
      nand_cmd_req = 1;
      step();
      `CHK("cmd_go", 1'b1, nand_cmd_go)
      flash_ready = 0;
      repeat (3) step();
      `CHK("cmd_busy", 1'b0, nand_cmd_go)
      flash_ready = 1;
      repeat (3) step();
      `CHK("cmd_ready", 1'b1, nand_cmd_go)
      nand_cmd_req = 0;
      wr(4'hF, 12'h000, 3'h3);
      `CHK("sflash", 5'h0F, {nand_ce_func, sflash_func})
      wr(4'h8, 12'h000, 3'h2);
      repeat (4) step();
      `CHK("sflash_hold", 4'h7, sflash_func)
      `CHK("f_mode3", 3'h2, f_mode_q[3])
      wr(4'h0, 12'h00F, 3'h1);
      `CHK("d_field", 2'h1, d_mode_q[0])
      `CHK("d_bus", 12'h00F, d_bus_func)
      wr(4'h0, 12'h001, 3'h2);
      `CHK("d_bus", 12'h00E, d_bus_func)
      bus_prog_we = 1; hi_addr_wdata = 5'h15;
      step();
      bus_prog_we = 0;
      `CHK("addr_en", 25'h15FFFFF, addr_line_en)
      `CHK("we0_oe", 1'b1, byte0_write_strobe_oe)
      `CHK("nor_hi", 5'h15, nor_hi_addr)
      bus_we0_n = 0; bus_cs0_n = 0; bus_rd_n = 0;
      step();
      `CHK("we0_pin", 1'b0, byte0_write_strobe_n)
      `CHK("cs_rd_pin", 2'h0, {area0_select_n, read_strobe_n})
      bus_we0_n = 1; bus_cs0_n = 1; bus_rd_n = 1;
      `CHK("dbg_idle", 1'b0, debug_rst)
      emu_trst_n = 0;
      #1;
      `CHK("dbg_async", 1'b1, debug_rst)
      step();
      emu_trst_n = 1;
      step();
      `CHK("dbg_hold", 1'b1, debug_rst)
      step();
      `CHK("dbg_free", 1'b0, debug_rst)
      emu_attached = 0;
      #1;
      `CHK("dbg_unplugged", 1'b1, debug_rst)
      give_verdict();
   end
endmodule : fps_pin_select_test
